// ==== rtl/pll_pd_divider_lock_detect.v ====
// Phase comparator masking, reference and feedback dividers, and windowed lock indicator.
`timescale 1ns/1ps
`include "pll_pd_lock_defs.vh"
module pll_pd_divider_lock_detect (
   input  wire        mclk,
   input  wire        reset_n,
   input  wire        reg_write,
   input  wire        reg_read,
   input  wire [5:0]  reg_addr,
   input  wire [23:0] reg_wdata,
   output reg  [23:0] reg_rdata,
   output reg         reg_rvalid,
   input  wire        fractional_mode,
   input  wire        reference_input_pin,
   input  wire        vco_feedback_pin,
   output reg         charge_pump_up,
   output reg         charge_pump_down,
   output reg         charge_pump_oe,
   output reg         ref_buffer_high_freq,
   output reg         lock_indicator
);

   // -------------------------------------------------------------------------
   // Register file
   // -------------------------------------------------------------------------
   reg [23:0] reference_divide_ratio;
   reg [23:0] feedback_divide_ratio;
   reg [23:0] lock_detect_config;
   reg [23:0] reference_buffer_config;
   reg [23:0] pump_current_config;
   reg [23:0] phase_detector_control;
   reg        locked;

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reference_divide_ratio  <= `RST_REFERENCE_DIVIDE_RATIO;
         feedback_divide_ratio   <= `RST_FEEDBACK_DIVIDE_RATIO;
         lock_detect_config      <= `RST_LOCK_DETECT_CONFIG;
         reference_buffer_config <= `RST_REFERENCE_BUFFER_CONFIG;
         pump_current_config     <= `RST_PUMP_CURRENT_CONFIG;
         phase_detector_control  <= `RST_PHASE_DETECTOR_CONTROL;
      end else if (reg_write) begin
         case (reg_addr)
            `OFS_REFERENCE_DIVIDE_RATIO: begin
               reference_divide_ratio <= reg_wdata;
            end
            `OFS_FEEDBACK_DIVIDE_RATIO: begin
               feedback_divide_ratio <= reg_wdata;
            end
            `OFS_LOCK_DETECT_CONFIG: begin
               lock_detect_config <= reg_wdata;
            end
            `OFS_REFERENCE_BUFFER_CONFIG: begin
               reference_buffer_config <= reg_wdata;
            end
            `OFS_PUMP_CURRENT_CONFIG: begin
               pump_current_config <= reg_wdata;
            end
            `OFS_PHASE_DETECTOR_CONTROL: begin
               phase_detector_control <= reg_wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // Read data is registered; status is read from the same clock as lock updates.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata  <= 24'h000000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_read;
         if (reg_read) begin
            case (reg_addr)
               `OFS_REFERENCE_DIVIDE_RATIO: begin
                  reg_rdata <= reference_divide_ratio;
               end
               `OFS_FEEDBACK_DIVIDE_RATIO: begin
                  reg_rdata <= feedback_divide_ratio;
               end
               `OFS_LOCK_DETECT_CONFIG: begin
                  reg_rdata <= lock_detect_config;
               end
               `OFS_REFERENCE_BUFFER_CONFIG: begin
                  reg_rdata <= reference_buffer_config;
               end
               `OFS_PUMP_CURRENT_CONFIG: begin
                  reg_rdata <= pump_current_config;
               end
               `OFS_PHASE_DETECTOR_CONTROL: begin
                  reg_rdata <= phase_detector_control;
               end
               `OFS_SYNTH_STATUS: begin
                  reg_rdata <= {22'h000000, locked, 1'b0};
               end
               default: begin
                  reg_rdata <= 24'h000000;
               end
            endcase
         end
      end
   end

   // -------------------------------------------------------------------------
   // Pin synchronisers and edge detection
   // -------------------------------------------------------------------------
   reg [2:0] ref_sync;
   reg [2:0] vco_sync;

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ref_sync <= 3'h0;
         vco_sync <= 3'h0;
      end else begin
         ref_sync <= {ref_sync[1:0], reference_input_pin};
         vco_sync <= {vco_sync[1:0], vco_feedback_pin};
      end
   end

   wire ref_rise = ref_sync[1] & ~ref_sync[2];
   wire vco_rise = vco_sync[1] & ~vco_sync[2];

   // -------------------------------------------------------------------------
   // Dividers
   // -------------------------------------------------------------------------
   reg  [`FB_DIV_WIDTH-1:0] fb_ratio;
   wire [`FB_DIV_WIDTH-1:0] fb_req = feedback_divide_ratio[`FB_DIV_WIDTH-1:0];
   wire                     ref_edge;
   wire                     fb_edge;

   // Out-of-range ratios are clamped so the comparison rate stays in the legal span.
   always @* begin
      fb_ratio = fb_req;
      if (fractional_mode) begin
         if (fb_req < `FB_MIN_FRACTIONAL) begin
            fb_ratio = `FB_MIN_FRACTIONAL;
         end else if (fb_req > `FB_MAX_FRACTIONAL) begin
            fb_ratio = `FB_MAX_FRACTIONAL;
         end
      end else if (fb_req < `FB_MIN_INTEGER) begin
         fb_ratio = `FB_MIN_INTEGER;
      end
   end

   pulse_divider #(
      .WIDTH     (`REF_DIV_WIDTH)
   ) ref_divider (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .in_pulse  (ref_rise),
      .ratio     (reference_divide_ratio[`REF_DIV_WIDTH-1:0]),
      .out_pulse (ref_edge)
   );

   pulse_divider #(
      .WIDTH     (`FB_DIV_WIDTH)
   ) fb_divider (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .in_pulse  (vco_rise),
      .ratio     (fb_ratio),
      .out_pulse (fb_edge)
   );

   // -------------------------------------------------------------------------
   // Phase comparator and charge pump drive
   // -------------------------------------------------------------------------
   reg  pfd_up;
   reg  pfd_down;
   wire up_enable  = phase_detector_control[`PDC_UP_ENABLE_BIT];
   wire dn_enable  = phase_detector_control[`PDC_DOWN_ENABLE_BIT];
   wire force_pump_high = phase_detector_control[`PDC_FORCE_HIGH_BIT];
   wire force_pump_low  = phase_detector_control[`PDC_FORCE_LOW_BIT];

   // Three-state comparator: the leading edge raises its request, the second clears both.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pfd_up   <= 1'b0;
         pfd_down <= 1'b0;
      end else if ((pfd_up | ref_edge) & (pfd_down | fb_edge)) begin
         pfd_up   <= 1'b0;
         pfd_down <= 1'b0;
      end else begin
         pfd_up   <= pfd_up | ref_edge;
         pfd_down <= pfd_down | fb_edge;
      end
   end

   // Force wins over masking so a test can rail the oscillator with the comparator masked.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         charge_pump_up       <= 1'b0;
         charge_pump_down     <= 1'b0;
         charge_pump_oe       <= 1'b0;
         ref_buffer_high_freq <= 1'b0;
      end else begin
         charge_pump_up       <= force_pump_high | (pfd_up & up_enable & ~force_pump_low);
         charge_pump_down     <= force_pump_low | (pfd_down & dn_enable & ~force_pump_high);
         charge_pump_oe       <= up_enable | dn_enable | force_pump_high | force_pump_low;
         ref_buffer_high_freq <= reference_buffer_config[`RBC_HIGH_FREQ_BIT];
      end
   end

   // -------------------------------------------------------------------------
   // Lock window length
   // -------------------------------------------------------------------------
   wire [1:0]  timer_speed  = lock_detect_config[`LDC_TIMER_SPEED_MSB:`LDC_TIMER_SPEED_LSB];
   wire [2:0]  timer_divide = lock_detect_config[`LDC_TIMER_DIV_MSB:`LDC_TIMER_DIV_LSB];
   wire        win_digital  = lock_detect_config[`LDC_WINDOW_DIGITAL_BIT];
   wire [2:0]  lock_thresh  = lock_detect_config[`LDC_THRESHOLD_MSB:`LDC_THRESHOLD_LSB];
   wire        detect_enable = lock_detect_config[`LDC_ENABLE_BIT];
   wire [383:0] win_table   = {`WIN_ROW_SPEED3, `WIN_ROW_SPEED2, `WIN_ROW_SPEED1, `WIN_ROW_SPEED0};
   wire [4:0]  win_index    = {timer_speed, timer_divide};
   wire [11:0] digital_x10  = win_table[win_index * 12 +: 12];
   localparam [11:0] ANALOG_X10 = `ANALOG_WINDOW_X10;
   localparam [11:0] PERIOD_X10 = `MCLK_PERIOD_X10;
   wire [11:0] window_x10   = win_digital ? digital_x10 : ANALOG_X10;
   wire [11:0] window_raw   = window_x10 / PERIOD_X10;
   // A window shorter than one clock is widened to one cycle, so edges up to one cycle apart still match.
   wire [3:0]  window_cyc   = (window_raw == 12'h000) ? 4'h1 : window_raw[3:0];

   // -------------------------------------------------------------------------
   // Lock detector
   // -------------------------------------------------------------------------
   reg       pend_ref;
   reg       pend_fb;
   reg [3:0] win_timer;
   reg [3:0] hit_count;
   reg       next_pend_ref;
   reg       next_pend_fb;
   reg [3:0] next_win_timer;
   reg [3:0] next_hit_count;
   reg       next_locked;
   reg       hit;
   reg       miss;

   always @* begin
      next_pend_ref  = pend_ref;
      next_pend_fb   = pend_fb;
      next_win_timer = win_timer;
      hit            = 1'b0;
      miss           = 1'b0;
      if (pend_ref | pend_fb) begin
         if ((pend_ref & fb_edge) | (pend_fb & ref_edge)) begin
            hit           = 1'b1;
            next_pend_ref = 1'b0;
            next_pend_fb  = 1'b0;
         end else if ((pend_ref & ref_edge) | (pend_fb & fb_edge) | (win_timer >= window_cyc)) begin
            miss           = 1'b1;
            next_pend_ref  = pend_ref & ref_edge;
            next_pend_fb   = pend_fb & fb_edge;
            next_win_timer = 4'h1;
         end else begin
            next_win_timer = win_timer + 4'h1;
         end
      end else if (ref_edge & fb_edge) begin
         hit = 1'b1;
      end else if (ref_edge | fb_edge) begin
         next_pend_ref  = ref_edge;
         next_pend_fb   = fb_edge;
         next_win_timer = 4'h1;
      end
      next_hit_count = hit_count;
      next_locked    = locked;
      if (miss) begin
         next_hit_count = 4'h0;
         next_locked    = 1'b0;
      end else if (hit) begin
         if (hit_count != 4'h8) begin
            next_hit_count = hit_count + 4'h1;
         end
         next_locked = (next_hit_count >= {1'b0, lock_thresh});
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pend_ref       <= 1'b0;
         pend_fb        <= 1'b0;
         win_timer      <= 4'h0;
         hit_count      <= 4'h0;
         locked         <= 1'b0;
         lock_indicator <= 1'b0;
      end else if (!detect_enable) begin
         pend_ref       <= 1'b0;
         pend_fb        <= 1'b0;
         win_timer      <= 4'h0;
         hit_count      <= 4'h0;
         locked         <= 1'b0;
         lock_indicator <= 1'b0;
      end else begin
         pend_ref       <= next_pend_ref;
         pend_fb        <= next_pend_fb;
         win_timer      <= next_win_timer;
         hit_count      <= next_hit_count;
         locked         <= next_locked;
         lock_indicator <= next_locked;
      end
   end

endmodule

// ==== rtl/pulse_divider.v ====
// Edge counter that emits one pulse per programmed number of input pulses.
`timescale 1ns/1ps
module pulse_divider #(
   parameter WIDTH = 14
) (
   input  wire             mclk,
   input  wire             reset_n,
   input  wire             in_pulse,
   input  wire [WIDTH-1:0] ratio,
   output reg              out_pulse
);
   reg [WIDTH-1:0] count;
   wire [WIDTH-1:0] last = (ratio == {WIDTH{1'b0}}) ? {WIDTH{1'b0}} : ratio - {{(WIDTH-1){1'b0}}, 1'b1};

   // A ratio of zero behaves as one, so the divider never stalls.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         count     <= {WIDTH{1'b0}};
         out_pulse <= 1'b0;
      end else begin
         out_pulse <= 1'b0;
         if (in_pulse) begin
            if (count >= last) begin
               count     <= {WIDTH{1'b0}};
               out_pulse <= 1'b1;
            end else begin
               count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule

// ==== shared/pll_pd_lock_defs.vh ====
// Offsets, field positions, reset values and timing constants of the phase path control.
`ifndef PLL_PD_LOCK_DEFS_VH
`define PLL_PD_LOCK_DEFS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_REFERENCE_DIVIDE_RATIO  6'h02
`define OFS_FEEDBACK_DIVIDE_RATIO   6'h03
`define OFS_LOCK_DETECT_CONFIG      6'h07
`define OFS_REFERENCE_BUFFER_CONFIG 6'h08
`define OFS_PUMP_CURRENT_CONFIG     6'h09
`define OFS_PHASE_DETECTOR_CONTROL  6'h0B
`define OFS_SYNTH_STATUS            6'h12

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PDC_UP_ENABLE_BIT     5
`define PDC_DOWN_ENABLE_BIT   6
`define PDC_FORCE_HIGH_BIT    9
`define PDC_FORCE_LOW_BIT     10
`define RBC_HIGH_FREQ_BIT     21
`define LDC_THRESHOLD_MSB     2
`define LDC_THRESHOLD_LSB     0
`define LDC_TIMER_DIV_MSB     7
`define LDC_TIMER_DIV_LSB     5
`define LDC_WINDOW_DIGITAL_BIT 6
`define LDC_TIMER_SPEED_MSB   9
`define LDC_TIMER_SPEED_LSB   8
`define LDC_ENABLE_BIT        11
`define STATUS_LOCK_BIT       1
`define REF_DIV_WIDTH         14
`define FB_DIV_WIDTH          19

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_REFERENCE_DIVIDE_RATIO  24'h000001
`define RST_FEEDBACK_DIVIDE_RATIO   24'h000014
`define RST_LOCK_DETECT_CONFIG      24'h000000
`define RST_REFERENCE_BUFFER_CONFIG 24'h000000
`define RST_PUMP_CURRENT_CONFIG     24'h000000
`define RST_PHASE_DETECTOR_CONTROL  24'h000060

// ----------------------------------------------------------------------------
// Divider ranges
// ----------------------------------------------------------------------------
`define FB_MIN_INTEGER    19'h00010
`define FB_MAX_INTEGER    19'h7FFFF
`define FB_MIN_FRACTIONAL 19'h00014
`define FB_MAX_FRACTIONAL 19'h7FFFB

// ----------------------------------------------------------------------------
// Timing, windows in tenths of a nanosecond
// ----------------------------------------------------------------------------
`define MCLK_PERIOD_NS      50
`define MCLK_PERIOD_X10     (`MCLK_PERIOD_NS * 10)
`define ANALOG_WINDOW_NS    10
`define ANALOG_WINDOW_X10   (`ANALOG_WINDOW_NS * 10)
`define WIN_ROW_SPEED0      96'h79E3E82121220AA06E050041
`define WIN_ROW_SPEED1      96'h9F65142A81680D2080059046
`define WIN_ROW_SPEED2      96'hAA05642D017C0DC08505C047
`define WIN_ROW_SPEED3      96'hD346B83701D610409A06604C

`endif

// ==== verif/pin_source.sv ====
// Reference and feedback pin oscillators of equal period, with start delays.
`timescale 1ns/1ps
module pin_source #(
   parameter HALF = 3
) (
   input  wire       mclk,
   input  wire       run,
   input  wire [7:0] ref_delay,
   input  wire [7:0] fb_delay,
   output reg        reference_input_pin,
   output reg        vco_feedback_pin
);
   integer t = 0;
   initial reference_input_pin = 1'b0;
   initial vco_feedback_pin = 1'b0;
   // Pins rest low while stopped, so each run restarts both dividers from a known phase.
   always @(posedge mclk) begin
      t <= run ? t + 1 : 0;
      reference_input_pin <= run && t >= ref_delay && ((t - ref_delay) % (2 * HALF)) < HALF;
      vco_feedback_pin <= run && t >= fb_delay && ((t - fb_delay) % (2 * HALF)) < HALF;
   end
endmodule

// ==== verif/pll_pd_divider_lock_detect_assertions.sv ====
// Port-level checker for the phase path control block, with its bind.
`timescale 1ns/1ps
`include "pll_pd_lock_defs.vh"
module pll_pd_divider_lock_detect_assertions (
   input wire        mclk,
   input wire        reset_n,
   input wire        reg_write,
   input wire        reg_read,
   input wire [5:0]  reg_addr,
   input wire [23:0] reg_wdata,
   input wire [23:0] reg_rdata,
   input wire        reg_rvalid,
   input wire        fractional_mode,
   input wire        reference_input_pin,
   input wire        vco_feedback_pin,
   input wire        charge_pump_up,
   input wire        charge_pump_down,
   input wire        charge_pump_oe,
   input wire        ref_buffer_high_freq,
   input wire        lock_indicator
);
   // --------
   // Shadow of the control bits
   // --------
   // Control checks wait four quiet cycles after any write, so register and pump latency never fire them.
   reg [3:0] pdc;
   reg       rbc;
   reg       lde;
   reg [2:0] quiet;
   wire      settled = quiet[2];
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pdc <= 4'h3;
         rbc <= 1'b0;
         lde <= 1'b0;
         quiet <= 3'h0;
      end else if (reg_write) begin
         quiet <= 3'h0;
         if (reg_addr == `OFS_PHASE_DETECTOR_CONTROL) pdc <= {reg_wdata[10:9], reg_wdata[6:5]};
         if (reg_addr == `OFS_REFERENCE_BUFFER_CONFIG) rbc <= reg_wdata[21];
         if (reg_addr == `OFS_LOCK_DETECT_CONFIG) lde <= reg_wdata[11];
      end else if (!settled) begin
         quiet <= quiet + 3'h1;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   property p_up_mask;
      settled && !pdc[0] && !pdc[2] |-> !charge_pump_up;
   endproperty
   a_up_mask: assert property (p_up_mask) else $error("pump up while masked");
   property p_down_mask;
      settled && !pdc[1] && !pdc[3] |-> !charge_pump_down;
   endproperty
   a_down_mask: assert property (p_down_mask) else $error("pump down while masked");
   property p_tristate;
      settled && pdc == 4'h0 |-> !charge_pump_oe;
   endproperty
   a_tristate: assert property (p_tristate) else $error("pump driven while both masked");
   property p_force_high;
      settled && pdc[2] |-> charge_pump_up && charge_pump_oe;
   endproperty
   a_force_high: assert property (p_force_high) else $error("forced pump up missing");
   property p_force_low;
      (settled && pdc[3]) [*2] |-> charge_pump_down && charge_pump_oe;
   endproperty
   a_force_low: assert property (p_force_low) else $error("forced pump down missing");
   property p_buffer_mode;
      settled |-> ref_buffer_high_freq == rbc;
   endproperty
   a_buffer_mode: assert property (p_buffer_mode) else $error("buffer mode differs");
   property p_lock_off;
      settled && !lde |-> !lock_indicator;
   endproperty
   a_lock_off: assert property (p_lock_off) else $error("lock while detector off");
   property p_status;
      reg_rvalid && $past(reg_addr) == `OFS_SYNTH_STATUS |-> reg_rdata == {22'h0, $past(lock_indicator), 1'b0};
   endproperty
   a_status: assert property (p_status) else $error("status differs from lock output");
   property p_read_answer;
      reg_read |=> reg_rvalid ##1 (reg_rvalid == $past(reg_read));
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read answer late or long");
endmodule

bind pll_pd_divider_lock_detect pll_pd_divider_lock_detect_assertions pll_pd_divider_lock_detect_assertions_i (
   .mclk(mclk), .reset_n(reset_n), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fractional_mode(fractional_mode),
   .reference_input_pin(reference_input_pin), .vco_feedback_pin(vco_feedback_pin),
   .charge_pump_up(charge_pump_up), .charge_pump_down(charge_pump_down), .charge_pump_oe(charge_pump_oe),
   .ref_buffer_high_freq(ref_buffer_high_freq), .lock_indicator(lock_indicator));

// ==== verif/pll_pd_divider_lock_detect_tb_top.sv ====
// Self-checking bench for the phase path control block.
`timescale 1ns/1ps
`include "pll_pd_lock_defs.vh"
module pll_pd_divider_lock_detect_tb_top;
   // --------
   // Stimulus and checking
   // --------
   localparam CMP = 96;
   localparam SPAN = 300;
   reg          mclk = 1'b0;
   reg          reset_n = 1'b0;
   reg          reg_write = 1'b0;
   reg          reg_read = 1'b0;
   reg  [5:0]   reg_addr = 6'h00;
   reg  [23:0]  reg_wdata = 24'h000000;
   reg          fractional_mode = 1'b0;
   reg          run = 1'b0;
   reg  [7:0]   ref_delay = 8'h00;
   reg  [7:0]   fb_delay = 8'h00;
   reg  [23:0]  rv;
   wire [23:0]  reg_rdata;
   wire         reg_rvalid, ref_pin, fb_pin, up, dn, oe, hf, lock;
   integer      err_count = 0;
   integer      samples_checked = 0;
   integer      i, t2, t5, nu, nd, no;
   logic [23:0] expq[$];
   always #25 mclk = ~mclk;
   pll_pd_divider_lock_detect pll_pd_divider_lock_detect_i (
      .mclk(mclk), .reset_n(reset_n), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fractional_mode(fractional_mode),
      .reference_input_pin(ref_pin), .vco_feedback_pin(fb_pin), .charge_pump_up(up), .charge_pump_down(dn),
      .charge_pump_oe(oe), .ref_buffer_high_freq(hf), .lock_indicator(lock));
   pin_source pin_source_i (.mclk(mclk), .run(run), .ref_delay(ref_delay), .fb_delay(fb_delay),
      .reference_input_pin(ref_pin), .vco_feedback_pin(fb_pin));
   task chk(input string n, input [31:0] e, input [31:0] g);
      samples_checked = samples_checked + 1;
      if (e !== g) begin
         err_count = err_count + 1;
         $display("[FAIL] %s expected %0h seen %0h", n, e, g);
      end
   endtask
   always @(posedge mclk) begin
      if (reg_rvalid === 1'b1) chk("read data", expq.pop_front(), reg_rdata);
   end
   task wr(input [5:0] a, input [23:0] d);
      @(posedge mclk);
      {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge mclk);
      reg_write <= 1'b0;
   endtask
   task rd(input [5:0] a, input [23:0] e);
      @(posedge mclk);
      {reg_read, reg_addr} <= {1'b1, a};
      expq.push_back(e);
      @(posedge mclk);
      reg_read <= 1'b0;
   endtask
   task start(input [7:0] rdl, input [7:0] fdl, input [23:0] rr, input [23:0] nn, input [23:0] ldc);
      @(posedge mclk);
      {reset_n, run, ref_delay, fb_delay} <= {2'b00, rdl, fdl};
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      wr(`OFS_REFERENCE_DIVIDE_RATIO, rr);
      wr(`OFS_FEEDBACK_DIVIDE_RATIO, nn);
      wr(`OFS_LOCK_DETECT_CONFIG, ldc);
      @(posedge mclk);
      run <= 1'b1;
   endtask
   task status(input e);
      repeat (20 * CMP) @(posedge mclk);
      rd(`OFS_SYNTH_STATUS, {22'h0, e, 1'b0});
   endtask
   task lock_time(input [2:0] th, output integer t);
      start(0, 0, 24'h000010, 24'h000010, 24'h000800 | th);
      t = 0;
      while (lock !== 1'b1 && t < 20 * CMP) begin
         @(posedge mclk);
         t = t + 1;
      end
   endtask
   function integer kind(input integer c);
      kind = c == 0 ? 0 : c == SPAN ? 2 : 1;
   endfunction
   task pump(input [7:0] rdl, input [7:0] fdl, input [23:0] pdc, input integer ku, kd, ko);
      start(rdl, fdl, 24'h000010, 24'h000010, 24'h000000);
      wr(`OFS_PHASE_DETECTOR_CONTROL, pdc);
      repeat (2 * CMP) @(posedge mclk);
      {nu, nd, no} = 0;
      repeat (SPAN) begin
         @(posedge mclk);
         nu = nu + (up === 1'b1);
         nd = nd + (dn === 1'b1);
         no = no + (oe === 1'b1);
      end
      chk("pump up", ku, kind(nu));
      chk("pump down", kd, kind(nd));
      chk("pump enable", ko, kind(no));
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // The tests need about 20000 cycles; the limit leaves more than double that.
   initial begin
      #3000000;
      err_count = err_count + 1;
      conclude;
   end
   initial begin
      void'($urandom(31));
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rd(`OFS_REFERENCE_DIVIDE_RATIO, `RST_REFERENCE_DIVIDE_RATIO);
      rd(`OFS_FEEDBACK_DIVIDE_RATIO, `RST_FEEDBACK_DIVIDE_RATIO);
      rd(`OFS_LOCK_DETECT_CONFIG, `RST_LOCK_DETECT_CONFIG);
      rd(`OFS_REFERENCE_BUFFER_CONFIG, `RST_REFERENCE_BUFFER_CONFIG);
      rd(`OFS_PUMP_CURRENT_CONFIG, `RST_PUMP_CURRENT_CONFIG);
      rd(`OFS_PHASE_DETECTOR_CONTROL, `RST_PHASE_DETECTOR_CONTROL);
      rd(6'h3F, 24'h000000);
      wr(`OFS_SYNTH_STATUS, 24'hFFFFFF);
      rd(`OFS_SYNTH_STATUS, 24'h000000);
      for (i = 0; i < 4; i = i + 1) begin
         rv = $urandom;
         wr(`OFS_PUMP_CURRENT_CONFIG, rv);
         rd(`OFS_PUMP_CURRENT_CONFIG, rv);
      end
      wr(`OFS_REFERENCE_DIVIDE_RATIO, 24'h003FFF);
      rd(`OFS_REFERENCE_DIVIDE_RATIO, 24'h003FFF);
      wr(`OFS_REFERENCE_BUFFER_CONFIG, 24'h200000);
      rd(`OFS_REFERENCE_BUFFER_CONFIG, 24'h200000);
      repeat (4) @(posedge mclk);
      chk("buffer mode", 1, hf);
      $display("registers done");
      lock_time(3'h2, t2);
      lock_time(3'h5, t5);
      chk("lock delay", 3 * CMP, t5 - t2);
      $display("threshold done");
      start(0, 4, 24'h000010, 24'h000010, 24'h000BE2);
      status(1'b1);
      start(4, 0, 24'h000010, 24'h000010, 24'h000BE2);
      status(1'b1);
      start(0, 12, 24'h000010, 24'h000010, 24'h000BE2);
      status(1'b0);
      start(0, 4, 24'h000010, 24'h000010, 24'h000802);
      status(1'b0);
      start(0, 0, 24'h000010, 24'h000010, 24'h000002);
      status(1'b0);
      $display("window done");
      start(0, 0, 24'h000010, 24'h000010, 24'h000802);
      status(1'b1);
      wr(`OFS_REFERENCE_DIVIDE_RATIO, 24'h000011);
      repeat (3 * CMP) @(posedge mclk);
      rd(`OFS_SYNTH_STATUS, 24'h000000);
      fractional_mode <= 1'b1;
      start(0, 0, 24'h000010, 24'h000010, 24'h000802);
      status(1'b0);
      start(0, 0, 24'h000014, 24'h000014, 24'h000802);
      status(1'b1);
      fractional_mode <= 1'b0;
      $display("divider done");
      pump(0, 8, 24'h000060, 1, 0, 2);
      pump(0, 8, 24'h000040, 0, 0, 2);
      pump(8, 0, 24'h000060, 0, 1, 2);
      pump(8, 0, 24'h000020, 0, 0, 2);
      pump(0, 8, 24'h000000, 0, 0, 0);
      pump(0, 8, 24'h000260, 2, 0, 2);
      pump(8, 0, 24'h000460, 0, 2, 2);
      $display("pump done");
      repeat (4) @(posedge mclk);
      conclude;
   end
endmodule
